// ### rtl/frs_host.sv
// host-side reset sequencer for an asynchronous parallel flash
// assumes rst_in is held through supply ramp; supplies_ok_in marks them good
// Functional notes
// RULE_01: wait supply setup before first access
// RULE_02: reset low 200ns, high 50ns before select
// RULE_03: select no earlier than 35us after reset
// RULE_04: pulse plus release not below reset-to-select
// RULE_05: select high at least 20ns between accesses
// RULE_06: device ignores controls during cold reset
// RULE_07: cold end: standby if reset high
// RULE_08: optional reset at power-on; latest time wins
// RULE_09: reset-to-select counted from supply setup end
// RULE_10: first read starts on select/enable/address change
// RULE_11: select low through reset reads current address
// RULE_12: early reset during cold reset stays cold
// RULE_13: reset after standby is warm reset
// RULE_14: warm reset aborts embedded operation
// RULE_15: after warm reset, standby on reset release
// RULE_16: incomplete power-on makes later reset cold
// RULE_17: ready_busy_n low during any reset
// RULE_18: reset begins at low level of reset pin
// RULE_19: device tracks cold-reset-complete flag
`timescale 1ns/100ps
`default_nettype none
module frs_host #(
	parameter int SUPPLY_SETUP_CYC = frs_pkg::SUPPLY_SETUP_CYC,
	parameter int RESET_TO_SELECT_CYC = frs_pkg::RESET_TO_SELECT_CYC
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic supplies_ok_in,
	input wire logic power_on_reset_in,
	input wire logic warm_reset_req_in,
	input wire logic access_req_in,
	input wire logic access_done_in,
	input wire logic ready_busy_n_in,
	output logic hw_reset_n_out,
	output logic chip_select_n_out,
	output logic access_grant_out,
	output logic link_ready_out,
	output logic device_busy_out
);
	localparam int CW = frs_pkg::CNT_W;

	// ****************************************
	// parameter checks
	// ****************************************
	// counts must fit the shared counter width
	if (SUPPLY_SETUP_CYC < 1 || SUPPLY_SETUP_CYC >= (1 << CW)) begin : g_bad_sup
		$error("supply setup count out of range");
	end

	if (RESET_TO_SELECT_CYC < 1 ||
		RESET_TO_SELECT_CYC >= (1 << CW)) begin : g_bad_rph
		$error("reset to select count out of range");
	end

	// ****************************************
	// pin synchronisation
	// ****************************************
	logic busy_n_sync;
	frs_sync u_busy_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.d_in(ready_busy_n_in),
		.q_out(busy_n_sync)
	);

	// ****************************************
	// sequencer
	// ****************************************
	typedef enum logic [2:0] {
		FRS_WAIT_SUPPLY, FRS_SETUP, FRS_PULSE, FRS_HOLD,
		FRS_RELEASE, FRS_IDLE, FRS_ACCESS, FRS_DESELECT
	} frs_state_e;

	// last value of each counted interval
	localparam logic [frs_pkg::CNT_W-1:0] SUPPLY_LAST =
		CW'(SUPPLY_SETUP_CYC - 1);
	localparam logic [frs_pkg::CNT_W-1:0] RPH_LAST =
		CW'(RESET_TO_SELECT_CYC - 1);
	localparam logic [frs_pkg::CNT_W-1:0] RP_LAST =
		CW'(frs_pkg::RESET_PULSE_CYC - 1);
	localparam logic [frs_pkg::CNT_W-1:0] RH_LAST =
		CW'(frs_pkg::RELEASE_TO_SELECT_CYC - 1);
	localparam logic [frs_pkg::CNT_W-1:0] CEH_LAST =
		CW'(frs_pkg::SELECT_HIGH_CYC - 1);

	frs_state_e state_reg;
	frs_state_e state_next;
	logic [frs_pkg::CNT_W-1:0] cnt_reg;
	logic [frs_pkg::CNT_W-1:0] cnt_next;
	// cycles since reset went low, saturating at RPH_LAST, one below the reset-to-select count
	logic [frs_pkg::CNT_W-1:0] low_cnt_reg;
	logic [frs_pkg::CNT_W-1:0] low_cnt_next;
	logic rst_n_reg;
	logic rst_n_next;
	logic cs_n_reg;
	logic cs_n_next;
	logic por_reg;
	logic por_next;
	logic rph_met;

	assign rph_met = (low_cnt_reg == RPH_LAST);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		low_cnt_next = low_cnt_reg;
		rst_n_next = rst_n_reg;
		cs_n_next = cs_n_reg;
		por_next = por_reg;
		if (!rst_n_reg && !rph_met)
			low_cnt_next = low_cnt_reg + 1'b1;
		case (state_reg)
			FRS_WAIT_SUPPLY: begin
				por_next = power_on_reset_in;
				cnt_next = '0;
				if (supplies_ok_in) begin
					state_next = FRS_SETUP;
					rst_n_next = !power_on_reset_in; // RULE_08
				end
			end
			FRS_SETUP: begin
				// reset low at power-on counts from setup end
				if (!rst_n_reg)
					low_cnt_next = '0; // RULE_09
				if (cnt_reg == SUPPLY_LAST) begin // RULE_01
					cnt_next = '0;
					state_next = por_reg ? FRS_PULSE : FRS_IDLE; // RULE_08
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			FRS_PULSE: begin
				rst_n_next = 1'b0; // RULE_18
				if (cnt_reg >= RP_LAST && rph_met) begin // RULE_02 RULE_04
					cnt_next = '0;
					rst_n_next = 1'b1;
					state_next = FRS_HOLD;
				end else if (cnt_reg < RP_LAST) begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			FRS_HOLD: begin
				if (cnt_reg == RH_LAST) begin // RULE_02
					cnt_next = '0;
					state_next = FRS_RELEASE;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			FRS_RELEASE: begin
				// device reports busy for the whole cold or warm reset
				if (busy_n_sync)
					state_next = FRS_IDLE; // RULE_17 RULE_03
			end
			FRS_IDLE: begin
				// a warm reset request wins over a pending access
				if (warm_reset_req_in) begin // RULE_13 RULE_14
					cnt_next = '0;
					low_cnt_next = '0;
					rst_n_next = 1'b0;
					state_next = FRS_PULSE;
				end else if (access_req_in && busy_n_sync) begin
					cs_n_next = 1'b0; // RULE_10
					state_next = FRS_ACCESS;
				end
			end
			FRS_ACCESS: begin
				if (access_done_in) begin
					cs_n_next = 1'b1;
					cnt_next = '0;
					state_next = FRS_DESELECT;
				end
			end
			FRS_DESELECT: begin
				if (cnt_reg >= CEH_LAST) // RULE_05
					state_next = FRS_IDLE;
				else
					cnt_next = cnt_reg + 1'b1;
			end
			default: begin
				state_next = FRS_WAIT_SUPPLY;
				rst_n_next = 1'b1;
				cs_n_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= FRS_WAIT_SUPPLY;
			cnt_reg <= '0;
			low_cnt_reg <= '0;
			rst_n_reg <= 1'b1;
			cs_n_reg <= 1'b1;
			por_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			low_cnt_reg <= low_cnt_next;
			rst_n_reg <= rst_n_next;
			cs_n_reg <= cs_n_next;
			por_reg <= por_next;
		end
	end

	assign hw_reset_n_out = rst_n_reg;
	assign chip_select_n_out = cs_n_reg;
	assign access_grant_out = (state_reg == FRS_ACCESS);
	assign link_ready_out = (state_reg == FRS_IDLE) && busy_n_sync;
	assign device_busy_out = !busy_n_sync;
endmodule // frs_host
`default_nettype wire

// ### rtl/frs_pkg.sv
// constants for the flash reset sequencer host controller
// assumes a 250 MHz clk_in
`default_nettype none
package frs_pkg;
	localparam int CLK_MHZ = 250;
	// least times in their natural units
	localparam int SUPPLY_SETUP_US = 300;
	localparam int RESET_TO_SELECT_US = 35;
	localparam int RESET_PULSE_NS = 200;
	localparam int RELEASE_TO_SELECT_NS = 50;
	localparam int SELECT_HIGH_NS = 20;
	// cycle counts, least times rounded up
	localparam int SUPPLY_SETUP_CYC = SUPPLY_SETUP_US * CLK_MHZ;
	localparam int RESET_TO_SELECT_CYC = RESET_TO_SELECT_US * CLK_MHZ;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int RELEASE_TO_SELECT_CYC =
		(RELEASE_TO_SELECT_NS * CLK_MHZ + 999) / 1000;
	localparam int SELECT_HIGH_CYC = (SELECT_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 20;
endpackage
`default_nettype wire

// ### rtl/frs_sync.sv
// two flip-flop synchroniser for a pin input
// assumes the input is asynchronous to clk_in
`timescale 1ns/100ps
`default_nettype none
module frs_sync (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic d_in,
	output logic q_out
);
	logic meta_reg;
	logic meta_next;
	logic q_reg;
	logic q_next;
	always_comb begin
		meta_next = d_in;
		q_next = meta_reg;
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_reg <= 1'b1;
			q_reg <= 1'b1;
		end else begin
			meta_reg <= meta_next;
			q_reg <= q_next;
		end
	end
	assign q_out = q_reg;
endmodule // frs_sync
`default_nettype wire

// ### sim/frs_flash_model.sv
// flash device model: busy while cold or warm reset runs
// assumes pwr_in high once both supplies are good
`timescale 1ns/100ps
`default_nettype none
module frs_flash_model #(parameter int COLD = 30, parameter int WARM = 8) (
	input wire logic clk_in,
	input wire logic pwr_in,
	input wire logic rst_n_in,
	output logic rdy_out
);
	logic done_reg;
	int cnt_reg;
	always_ff @(posedge clk_in) begin
		if (!pwr_in) begin
			done_reg <= 1'h0;
			cnt_reg <= COLD;
		end else if (cnt_reg != 0) begin
			cnt_reg <= cnt_reg - 1;
		end else if (!rst_n_in && done_reg) begin
			cnt_reg <= WARM;
		end else begin
			done_reg <= 1'h1;
		end
	end
	assign rdy_out = pwr_in && cnt_reg == 0 && rst_n_in;
endmodule // frs_flash_model
`default_nettype wire

// ### sim/frs_host_asserts.sv
// assertions on the host reset sequencer ports
// assumes binding to frs_host with its cycle parameters
`timescale 1ns/100ps
`default_nettype none
module frs_host_asserts #(
	parameter int SUPPLY_SETUP_CYC = 20,
	parameter int RESET_TO_SELECT_CYC = 10
) (
	input wire logic clk_in, rst_in, supplies_ok_in, power_on_reset_in,
	input wire logic warm_reset_req_in, access_req_in, access_done_in,
	input wire logic ready_busy_n_in, hw_reset_n_out, chip_select_n_out,
	input wire logic access_grant_out, link_ready_out, device_busy_out
);
	int lo_reg, hi_reg, csh_reg, ok_reg;
	always_ff @(posedge clk_in) begin
		lo_reg <= hw_reset_n_out ? 0 : lo_reg + 1;
		hi_reg <= hw_reset_n_out ? hi_reg + 1 : 0;
		csh_reg <= chip_select_n_out ? csh_reg + 1 : 0;
		ok_reg <= supplies_ok_in ? ok_reg + 1 : 0;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence sel_s;
		$fell(chip_select_n_out);
	endsequence
	sequence take_s;
		link_ready_out && access_req_in && !warm_reset_req_in;
	endsequence
	pulse_width_a: assert property (
		$rose(hw_reset_n_out) |-> lo_reg >= frs_pkg::RESET_PULSE_CYC &&
		lo_reg >= RESET_TO_SELECT_CYC) else $error("reset pulse short");
	release_gap_a: assert property (
		sel_s |-> hi_reg >= frs_pkg::RELEASE_TO_SELECT_CYC)
		else $error("select too soon after reset");
	select_gap_a: assert property (
		sel_s |-> csh_reg >= frs_pkg::SELECT_HIGH_CYC)
		else $error("select high too short");
	supply_wait_a: assert property (
		sel_s |-> ok_reg >= SUPPLY_SETUP_CYC) else $error("select before setup");
	ready_first_a: assert property (
		sel_s |-> !$past(device_busy_out)) else $error("select while busy");
	reset_hold_a: assert property (
		!hw_reset_n_out |-> chip_select_n_out) else $error("select in reset");
	access_take_a: assert property (
		take_s |=> !chip_select_n_out && access_grant_out)
		else $error("access not taken");
	warm_start_a: assert property (
		link_ready_out && warm_reset_req_in |=> !hw_reset_n_out)
		else $error("warm reset not started");
	release_end_a: assert property (
		access_grant_out && access_done_in |=> chip_select_n_out [*5])
		else $error("select not released");
endmodule // frs_host_asserts
bind frs_host frs_host_asserts #(.SUPPLY_SETUP_CYC(SUPPLY_SETUP_CYC),
	.RESET_TO_SELECT_CYC(RESET_TO_SELECT_CYC)) i_chk (.*);
`default_nettype wire

// ### sim/flash_reset_sequencer_bench.sv
// bench for the host reset sequencer against a flash model
// assumes the checker binds itself to frs_host
`timescale 1ns/100ps
`default_nettype none
module flash_reset_sequencer_bench;
	logic clk_in = 1'h0, rst_in = 1'h1, supplies_ok_in = 1'h0;
	logic power_on_reset_in = 1'h0, warm_reset_req_in = 1'h0;
	logic access_req_in = 1'h0, access_done_in = 1'h0;
	logic ready_busy_n_in, hw_reset_n_out, chip_select_n_out;
	logic access_grant_out, link_ready_out, device_busy_out;
	int bad_count = 0, num_checks = 0;
	always #2 clk_in = ~clk_in;
	frs_host #(.SUPPLY_SETUP_CYC(20), .RESET_TO_SELECT_CYC(10)) i_dut (.*);
	frs_flash_model i_dev (.clk_in(clk_in), .pwr_in(supplies_ok_in),
		.rst_n_in(hw_reset_n_out), .rdy_out(ready_busy_n_in));
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s exp %0h seen %0h", n, e, s);
		end
	endtask
	task automatic tick();
		@(posedge clk_in);
	endtask
	task automatic wait_idle(output int n, output logic saw);
		n = 0;
		saw = 1'h0;
		while (link_ready_out !== 1'h1 && n < 400) begin
			tick();
			#1;
			n++;
			saw |= device_busy_out;
		end
	endtask
	task automatic t_power(logic p);
		int n;
		logic saw;
		tick();
		rst_in <= 1'h1;
		supplies_ok_in <= 1'h0;
		power_on_reset_in <= p;
		repeat (2) tick();
		rst_in <= 1'h0;
		supplies_ok_in <= 1'h1;
		wait_idle(n, saw);
		chk("setup", n >= 20, 1'h1);
		chk("por pulse", n >= 83, p);
		chk("cold busy", saw, 1'h1);
		$display("power test done");
	endtask
	task automatic t_access();
		int n;
		tick();
		access_req_in <= 1'h1;
		tick();
		#1;
		chk("cs low", chip_select_n_out, 1'h0);
		chk("grant", access_grant_out, 1'h1);
		tick();
		access_done_in <= 1'h1;
		tick();
		access_done_in <= 1'h0;
		#1;
		chk("cs rise", chip_select_n_out, 1'h1);
		n = 1;
		while (chip_select_n_out === 1'h1 && n < 50) begin
			tick();
			#1;
			n++;
		end
		chk("cs gap", n >= 5, 1'h1);
		chk("cs again", chip_select_n_out, 1'h0);
		tick();
		access_req_in <= 1'h0;
		access_done_in <= 1'h1;
		tick();
		access_done_in <= 1'h0;
		$display("access test done");
	endtask
	task automatic t_warm();
		int n;
		logic saw;
		wait_idle(n, saw);
		tick();
		warm_reset_req_in <= 1'h1;
		access_req_in <= 1'h1;
		tick();
		warm_reset_req_in <= 1'h0;
		#1;
		chk("rst low", hw_reset_n_out, 1'h0);
		chk("cs held", chip_select_n_out, 1'h1);
		wait_idle(n, saw);
		chk("warm busy", saw, 1'h1);
		chk("warm span", n >= 23, 1'h1);
		tick();
		#1;
		chk("first read", chip_select_n_out, 1'h0);
		tick();
		access_req_in <= 1'h0;
		access_done_in <= 1'h1;
		tick();
		access_done_in <= 1'h0;
		$display("warm test done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		wrap_up();
	end
	initial begin
		t_power(1'h1);
		t_access();
		t_warm();
		t_power(1'h0);
		wrap_up();
	end
endmodule // flash_reset_sequencer_bench
`default_nettype wire
